/* dfpm_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Host and driver model: the only party that moves power states
module dfpm_host
  import dfpm_pkg::*;
(
  input wire logic clk,
  output logic [dfpm_pkg::AW-1:0] reg_addr,
  output logic [dfpm_pkg::DW-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [dfpm_pkg::DW-1:0] reg_rdata
);
  import dfpm_pkg::*;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
  end
  // A quiet cycle after each strobe keeps two tasks from driving one time step
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
    @(posedge clk);
  endtask
  // Read data stands only in the cycle after the strobe; take it at the edge that ends it
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    @(posedge clk);
    d = reg_rdata;
  endtask
  // Wake acknowledge: clear status, keep enable, return to full power
  task automatic wake_ack(input logic [AW-1:0] a);
    wr(a, 32'h0000_8100);
  endtask
endmodule
`default_nettype wire

/* dfpm_pkg.sv */
package dfpm_pkg;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int N_CH = 2;
  localparam int N_MDM = 5;
  localparam int N_PIN = 2;
  localparam int N_SYNC = N_CH * N_MDM + N_PIN;
  localparam int RI_IDX = 3;
  localparam int SIN_IDX = 4;
  localparam int MASK_STRIDE = 8;
  localparam logic [AW-1:0] A_FILT = 8'h00;
  localparam logic [AW-1:0] A_PINCFG = 8'h04;
  localparam logic [AW-1:0] A_GSTAT = 8'h08;
  localparam logic [AW-1:0] A_PM0 = 8'h0C;
  localparam logic [AW-1:0] A_PM1 = 8'h10;
  localparam logic [AW-1:0] A_WMASK = 8'h14;
  localparam int FILT_LSB = 5;
  localparam int FILT_W = 3;
  localparam int PCFG_INT_LSB = 0;
  localparam int PCFG_PD_LSB = 2;
  localparam int PCFG_WK_LSB = 4;
  localparam int PCFG_W = 6;
  localparam int GST_PD_LSB = 22;
  localparam int GST_EN_LSB = 24;
  localparam int GST_SEL_LSB = 26;
  localparam int PM_EN_BIT = 8;
  localparam int PM_ST_BIT = 15;
  localparam logic [1:0] PS_D0 = 2'h0;
  localparam logic [1:0] PS_D1 = 2'h1;
  localparam logic [1:0] PS_D2 = 2'h2;
  localparam logic [1:0] PS_D3 = 2'h3;
  localparam logic [FILT_W-1:0] FILT_RST = 3'h0;
  localparam logic [PCFG_W-1:0] PCFG_RST = 6'h00;
  localparam logic [1:0] EN_RST = 2'h0;
  localparam logic [1:0] SEL_RST = 2'h3;
  localparam logic [N_CH*N_MDM-1:0] MASK_RST = 10'h000;
  localparam int CLK_MHZ = 250;
  localparam int FILT_UNIT_NS = 1000;
  localparam int FILT_UNIT_CYC = (FILT_UNIT_NS * CLK_MHZ + 999) / 1000;
  localparam int PRE_W = 8;
  localparam int TICK_W = 7;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(FILT_UNIT_CYC - 1);
  typedef logic [1:0] dfpm_ps_t;
endpackage

/* dfpm_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Each function holds own state: D0, D2, D3
// - Each function drives wake pin independently
// - Serial powerdown needs idle, no pending interrupts
// - Function 0 pin: non-interrupt level means powerdown
// - Function 0 request after filter; drop restarts
// - Function 0 request sets bit 22, interrupts
// - Only host writes change power states
// - Function 0 low: clock off, irq, BAR blocked
// - Function 1 low: port low power, irq, BAR
// - Wake only when enable bit 8 set
// - Wake bypasses filter, works when disabled
// - D3: ring trailing edge wakes channel
// - D2: unmasked modem or data change wakes
// - Wake masks clear after reset
// - Data wake in D2 restarts channel clock
// - Function 0 pin wake level, any low state
// - Wake sets status bit 15, write-one clears
// - Wake pin driven while status and enable
// - Only pins make function 1 requests
// - Function 1 pin level requests at once
// - Function 1 request sets bit 23, interrupts
// - Bits 22, 23 sticky, clear on read
// - Enables bits 24, 25 gate interrupts
// - Bits 26, 27 route pins, reset one
module dfpm_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [dfpm_pkg::AW-1:0] reg_addr,
  input wire logic [dfpm_pkg::DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [dfpm_pkg::DW-1:0] reg_rdata,
  input wire logic [dfpm_pkg::N_CH-1:0] ch_irq_pend,
  input wire logic [dfpm_pkg::N_CH-1:0] ch_tx_idle,
  input wire logic [dfpm_pkg::N_CH-1:0] ch_rx_idle,
  input wire logic [dfpm_pkg::N_CH*dfpm_pkg::N_MDM-1:0] modem_in,
  input wire logic [dfpm_pkg::N_PIN-1:0] multipurpose_pin,
  output logic pme_o,
  output logic pme_oe_b,
  output logic f0_int_req,
  output logic f1_int_req,
  output logic f0_irq_allow,
  output logic f1_irq_allow,
  output logic f0_bar_en,
  output logic f1_bar_en,
  output logic [dfpm_pkg::N_CH-1:0] uart_clk_en,
  output logic pport_low_power
);
  import dfpm_pkg::*;

  function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic is_low(input dfpm_ps_t ps);
    is_low = (ps != PS_D0);
  endfunction

  function automatic dfpm_ps_t next_ps(input dfpm_ps_t cur, input dfpm_ps_t req);
    next_ps = (req == PS_D1) ? cur : req;
  endfunction

  // Register state
  logic [FILT_W-1:0] filt_q;
  logic [PCFG_W-1:0] pcfg_q;
  logic [1:0] pd_en_q;
  logic [1:0] pin_sel_q;
  logic [1:0] pd_st_q;
  logic [1:0] pd_st_d;
  logic [N_CH*N_MDM-1:0] wmask_q;
  dfpm_ps_t ps0_q;
  dfpm_ps_t ps1_q;
  logic [1:0] pme_en_q;
  logic [1:0] pme_st_q;
  logic [1:0] pme_st_d;
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] rdata_d;

  // Address decode
  wire wr_filt = reg_wr & hit(reg_addr, A_FILT);
  wire wr_pcfg = reg_wr & hit(reg_addr, A_PINCFG);
  wire wr_gst = reg_wr & hit(reg_addr, A_GSTAT);
  wire wr_pm0 = reg_wr & hit(reg_addr, A_PM0);
  wire wr_pm1 = reg_wr & hit(reg_addr, A_PM1);
  wire wr_msk = reg_wr & hit(reg_addr, A_WMASK);
  wire rd_gst = reg_rd & hit(reg_addr, A_GSTAT);
  wire w1c_st = reg_wdata[PM_ST_BIT];

  // Synchronisers: three stages, a change is taken once stages two and three agree
  logic [N_SYNC-1:0] s1_q;
  logic [N_SYNC-1:0] s2_q;
  logic [N_SYNC-1:0] s3_q;
  logic [N_SYNC-1:0] st_q;
  logic [N_SYNC-1:0] prev_q;
  wire [N_SYNC-1:0] raw_in = {multipurpose_pin, modem_in};

  genvar gi;
  generate
    for (gi = 0; gi < N_SYNC; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          st_q[gi] <= 1'b0;
          prev_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= raw_in[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          st_q[gi] <= (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : st_q[gi];
          prev_q[gi] <= st_q[gi];
        end
      end
    end
  endgenerate

  wire [N_PIN-1:0] pin_lv = st_q[N_SYNC-1 -: N_PIN];
  wire [N_CH*N_MDM-1:0] mdm_lv = st_q[N_CH*N_MDM-1:0];
  wire [N_CH*N_MDM-1:0] mdm_prev = prev_q[N_CH*N_MDM-1:0];
  wire [N_CH*N_MDM-1:0] mdm_chg = mdm_lv ^ mdm_prev;
  wire [N_PIN-1:0] int_lvl = pcfg_q[PCFG_INT_LSB +: N_PIN];
  wire [N_PIN-1:0] pd_lvl = pcfg_q[PCFG_PD_LSB +: N_PIN];
  wire [N_PIN-1:0] wk_lvl = pcfg_q[PCFG_WK_LSB +: N_PIN];
  wire low0 = is_low(ps0_q);
  wire low1 = is_low(ps1_q);

  // Function 0 powerdown sources
  wire [N_CH-1:0] uart_pd = ~ch_irq_pend & ch_tx_idle & ch_rx_idle;
  wire [N_PIN-1:0] pin_pd0 = pin_lv ^ int_lvl;
  wire all_pd0 = (&uart_pd) & (&(pin_pd0 | pin_sel_q));

  // Filter: code n waits 2^(n-1) units of one microsecond, code zero disables it
  logic [PRE_W-1:0] pre_q;
  logic [TICK_W-1:0] tick_q;
  logic fired_q;
  wire [FILT_W-1:0] filt_code = filt_q;
  wire filt_clr = ~all_pd0 | (filt_code == 3'h0);
  wire [TICK_W-1:0] tick_tgt = TICK_W'(1) << (filt_code - 3'h1);
  wire pre_wrap = (pre_q == PRE_LAST);
  wire at_tgt = (tick_q == tick_tgt);
  wire pd0_req = ~filt_clr & ~fired_q & at_tgt;
  wire [PRE_W-1:0] pre_d = (filt_clr | pre_wrap) ? '0 : pre_q + PRE_W'(1);
  wire [TICK_W-1:0] tick_d = filt_clr ? '0 :
                             (pre_wrap & ~at_tgt) ? tick_q + TICK_W'(1) : tick_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_q <= '0;
      tick_q <= '0;
      fired_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      tick_q <= tick_d;
      fired_q <= ~filt_clr & (fired_q | pd0_req);
    end
  end

  // Function 1: pins only, no filter, edge of the indication makes one request
  logic pd1_prev_q;
  wire pd1_ind = |(pin_sel_q & ~(pin_lv ^ pd_lvl));
  wire pd1_req = pd1_ind & ~pd1_prev_q;
  wire [1:0] pd_set = {pd1_req, pd0_req};

  // A request in the read cycle survives the clear
  assign pd_st_d = pd_set | (pd_st_q & ~{2{rd_gst}});

  // Wake detection
  logic [N_CH-1:0] uart_wk;
  logic [N_CH-1:0] sin_wk;
  generate
    for (gi = 0; gi < N_CH; gi++) begin : g_wake
      wire [N_MDM-1:0] chg = mdm_chg[gi*N_MDM +: N_MDM];
      wire [N_MDM-1:0] msk = wmask_q[gi*N_MDM +: N_MDM];
      wire ri_fall = mdm_prev[gi*N_MDM+RI_IDX] & ~mdm_lv[gi*N_MDM+RI_IDX];
      wire wk_d3 = (ps0_q == PS_D3) & ri_fall;
      wire wk_d2 = (ps0_q == PS_D2) & (|(chg & ~msk));
      assign uart_wk[gi] = wk_d3 | wk_d2;
      assign sin_wk[gi] = (ps0_q == PS_D2) & chg[SIN_IDX] & ~msk[SIN_IDX];
    end
  endgenerate

  wire [N_PIN-1:0] pin_wk = ~(pin_lv ^ wk_lvl);
  wire wake0 = (|uart_wk) | (|(pin_wk & ~pin_sel_q));
  wire wake1 = |(pin_wk & pin_sel_q);
  wire [1:0] wake = {wake1, wake0};
  wire [1:0] pm_wr = {wr_pm1, wr_pm0};
  wire [1:0] st_clr = pm_wr & {2{w1c_st}};

  // Set wins over a write-one clear in the same cycle
  assign pme_st_d = (wake & pme_en_q) | (pme_st_q & ~st_clr);
  wire pme_drive = |(pme_st_q & pme_en_q);

  logic [N_CH-1:0] sin_run_q;

  // Register writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      filt_q <= FILT_RST;
      pcfg_q <= PCFG_RST;
      pd_en_q <= EN_RST;
      pin_sel_q <= SEL_RST;
      wmask_q <= MASK_RST;
    end else begin
      if (wr_filt) begin
        filt_q <= reg_wdata[FILT_LSB +: FILT_W];
      end
      if (wr_pcfg) begin
        pcfg_q <= reg_wdata[PCFG_W-1:0];
      end
      if (wr_gst) begin
        pd_en_q <= reg_wdata[GST_EN_LSB +: 2];
        pin_sel_q <= reg_wdata[GST_SEL_LSB +: 2];
      end
      if (wr_msk) begin
        wmask_q <= {reg_wdata[MASK_STRIDE +: N_MDM], reg_wdata[N_MDM-1:0]};
      end
    end
  end

  // Power state changes only by a host write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ps0_q <= PS_D0;
      ps1_q <= PS_D0;
      pme_en_q <= 2'h0;
    end else begin
      if (wr_pm0) begin
        ps0_q <= next_ps(ps0_q, reg_wdata[1:0]);
        pme_en_q[0] <= reg_wdata[PM_EN_BIT];
      end
      if (wr_pm1) begin
        ps1_q <= next_ps(ps1_q, reg_wdata[1:0]);
        pme_en_q[1] <= reg_wdata[PM_EN_BIT];
      end
    end
  end

  // Sticky flags and edge history
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pd_st_q <= 2'h0;
      pme_st_q <= 2'h0;
      // Synchroniser starts at 0, so a pin idling high would look like a fresh request
      pd1_prev_q <= 1'b1;
      sin_run_q <= '0;
    end else begin
      pd_st_q <= pd_st_d;
      pme_st_q <= pme_st_d;
      pd1_prev_q <= pd1_ind;
      sin_run_q <= low0 ? (sin_run_q | sin_wk) : '0;
    end
  end

  // Read mux
  wire [DW-1:0] rdw_filt = {24'h00_0000, filt_q, 5'h00};
  wire [DW-1:0] rdw_pcfg = {26'h000_0000, pcfg_q};
  wire [DW-1:0] rdw_gst = {4'h0, pin_sel_q, pd_en_q, pd_st_q, 22'h00_0000};
  wire [DW-1:0] rd_pm0 = {16'h0000, pme_st_q[0], 6'h00, pme_en_q[0], 6'h00, ps0_q};
  wire [DW-1:0] rd_pm1 = {16'h0000, pme_st_q[1], 6'h00, pme_en_q[1], 6'h00, ps1_q};
  wire [DW-1:0] rd_msk = {19'h0_0000, wmask_q[2*N_MDM-1:N_MDM], 3'h0, wmask_q[N_MDM-1:0]};

  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      unique case (1'b1)
        hit(reg_addr, A_FILT): rdata_d = rdw_filt;
        hit(reg_addr, A_PINCFG): rdata_d = rdw_pcfg;
        hit(reg_addr, A_GSTAT): rdata_d = rdw_gst;
        hit(reg_addr, A_PM0): rdata_d = rd_pm0;
        hit(reg_addr, A_PM1): rdata_d = rd_pm1;
        hit(reg_addr, A_WMASK): rdata_d = rd_msk;
        default: rdata_d = '0;
      endcase
    end
  end

  // Outputs, all registered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
      pme_o <= 1'b0;
      pme_oe_b <= 1'b1;
      f0_int_req <= 1'b0;
      f1_int_req <= 1'b0;
      f0_irq_allow <= 1'b1;
      f1_irq_allow <= 1'b1;
      f0_bar_en <= 1'b1;
      f1_bar_en <= 1'b1;
      uart_clk_en <= '1;
      pport_low_power <= 1'b0;
    end else begin
      reg_rdata <= rdata_d;
      pme_o <= 1'b0;
      pme_oe_b <= ~pme_drive;
      f0_int_req <= pd_st_q[0] & pd_en_q[0] & ~low0;
      f1_int_req <= pd_st_q[1] & pd_en_q[1] & ~low1;
      f0_irq_allow <= ~low0;
      f1_irq_allow <= ~low1;
      f0_bar_en <= ~low0;
      f1_bar_en <= ~low1;
      uart_clk_en <= {N_CH{~low0}} | sin_run_q;
      pport_low_power <= low1;
    end
  end

  // Checking helper: cycles that every function 0 source has held powerdown
  logic [15:0] pd_run_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pd_run_q <= '0;
    end else begin
      pd_run_q <= !all_pd0 ? '0 : (pd_run_q == 16'hFFFF) ? pd_run_q : pd_run_q + 16'h0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  ps_legal_a: assert property (
    ps0_q != PS_D1 && ps1_q != PS_D1)
    else $error("power state holds an unsupported code");

  ps_hold_a: assert property (
    !wr_pm0 && !wr_pm1 |=> $stable(ps0_q) && $stable(ps1_q))
    else $error("power state changed without a host write");

  pd_filter_a: assert property (
    pd0_req |-> int'(pd_run_q) >= FILT_UNIT_CYC * int'(tick_tgt))
    else $error("function 0 request before filter period");

  pd_sticky_a: assert property (
    pd_st_q[0] && !rd_gst |=> pd_st_q[0])
    else $error("powerdown status lost without a read");

  pd_rdclr_a: assert property (
    rd_gst && !pd_set[1] |=> !pd_st_q[1])
    else $error("powerdown status not cleared by read");

  pd1_now_a: assert property (
    pd1_ind && !pd1_prev_q |=> pd_st_q[1])
    else $error("function 1 request not immediate");

  low0_gate_a: assert property (
    low0 |=> !f0_int_req && !f0_bar_en && !f0_irq_allow)
    else $error("function 0 low state not gating");

  low1_gate_a: assert property (
    low1 |=> pport_low_power && !f1_bar_en && !f1_int_req)
    else $error("function 1 low state not gating");

  pme_gate_a: assert property (
    !pme_en_q[0] && !pme_st_q[0] |=> !pme_st_q[0])
    else $error("wake status set while wake disabled");

  pme_keep_a: assert property (
    pme_st_q[1] && !st_clr[1] |=> pme_st_q[1])
    else $error("wake status dropped without write one");

  pme_pin_a: assert property (
    pme_st_q[0] && pme_en_q[0] |=> !pme_oe_b ##0 !pme_o)
    else $error("wake pin not driven");

endmodule
`default_nettype wire

/* dual_function_power_manager_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_function_power_manager_bench;
  import dfpm_pkg::*;
  logic clk;
  logic rst_b;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [DW-1:0] reg_rdata;
  logic [N_CH-1:0] ch_irq_pend;
  logic [N_CH-1:0] ch_tx_idle;
  logic [N_CH-1:0] ch_rx_idle;
  logic [N_CH*N_MDM-1:0] modem_in;
  logic [N_PIN-1:0] multipurpose_pin;
  logic pme_o, pme_oe_b, f0_int_req, f1_int_req, f0_irq_allow, f1_irq_allow;
  logic f0_bar_en, f1_bar_en, pport_low_power;
  logic [N_CH-1:0] uart_clk_en;
  int err_count;
  int n_tests;
  logic [7:0] lf;

  dfpm_top i_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ch_irq_pend(ch_irq_pend),
    .ch_tx_idle(ch_tx_idle), .ch_rx_idle(ch_rx_idle), .modem_in(modem_in),
    .multipurpose_pin(multipurpose_pin), .pme_o(pme_o), .pme_oe_b(pme_oe_b),
    .f0_int_req(f0_int_req), .f1_int_req(f1_int_req), .f0_irq_allow(f0_irq_allow),
    .f1_irq_allow(f1_irq_allow), .f0_bar_en(f0_bar_en), .f1_bar_en(f1_bar_en),
    .uart_clk_en(uart_clk_en), .pport_low_power(pport_low_power));
  dfpm_host i_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [DW-1:0] pm_word(input logic [1:0] st, input logic en,
                                            input logic sts);
    return {16'h0000, sts, 6'h00, en, 6'h00, st};
  endfunction
  // Bit 10 pme_o, 9 pme_oe_b, 8/7 int_req, 6/5 irq_allow, 4/3 bar_en, 2:1 clk_en, 0 pport
  function automatic logic [DW-1:0] outs();
    return {21'h00_0000, pme_o, pme_oe_b, f0_int_req, f1_int_req, f0_irq_allow, f1_irq_allow,
            f0_bar_en, f1_bar_en, uart_clk_en, pport_low_power};
  endfunction

  task automatic chk(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] m, input logic [DW-1:0] e,
                      input string nm);
    logic [DW-1:0] v;
    i_host.rd(a, v);
    chk(nm, e, v & m);
  endtask
  task automatic ochk(input logic [DW-1:0] m, input logic [DW-1:0] e, input string nm);
    chk(nm, e, outs() & m);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Whole run is near 950 cycles; allow a wide margin
  initial begin
    repeat (6000) @(posedge clk);
    err_count++;
    close_out();
  end

  initial begin
    err_count = 0;
    n_tests = 0;
    lf = 8'h56;
    rst_b = 1'h0;
    ch_irq_pend = 2'h3;
    ch_tx_idle = 2'h3;
    ch_rx_idle = 2'h3;
    modem_in = 10'h000;
    multipurpose_pin = 2'h3;
    cyc(12);
    rst_b <= 1'h1;
    cyc(1);
    ochk(32'h0000_07FF, 32'h0000_027E, "reset outputs");
    rchk(A_GSTAT, 32'h0FC0_0000, 32'h0C00_0000, "status reset");
    rchk(A_WMASK, 32'h0000_1F1F, 32'h0000_0000, "wake masks");
    rchk(A_PM0, 32'h0000_8103, 32'h0000_0000, "f0 pm reset");
    rchk(8'h40, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
    // Pin levels: pin0 powerdown/wake at 0, pin1 powerdown/wake at 1
    i_host.wr(A_PINCFG, 32'h0000_0028);
    multipurpose_pin <= 2'h1;
    cyc(8);
    rchk(A_GSTAT, 32'h0000_0000, 32'h0000_0000, "status flush");
    $display("test reset finished");

    multipurpose_pin <= 2'h0;
    cyc(8);
    rchk(A_GSTAT, 32'h0080_0000, 32'h0080_0000, "f1 pd status");
    rchk(A_GSTAT, 32'h0080_0000, 32'h0000_0000, "f1 pd cleared");
    ochk(32'h0000_0280, 32'h0000_0200, "f1 no irq no wake");
    multipurpose_pin <= 2'h1;
    cyc(8);
    i_host.wr(A_GSTAT, 32'h0E00_0000);
    multipurpose_pin <= 2'h0;
    cyc(8);
    ochk(32'h0000_0080, 32'h0000_0080, "f1 irq");
    multipurpose_pin <= 2'h1;
    rchk(A_GSTAT, 32'h0000_0000, 32'h0000_0000, "status flush");
    $display("test f1 powerdown finished");

    // Filter code 1 is one unit; a busy blip midway must restart the wait
    i_host.wr(A_FILT, 32'h0000_0020);
    ch_irq_pend <= 2'h0;
    cyc(200);
    rchk(A_GSTAT, 32'h0040_0000, 32'h0000_0000, "f0 early");
    ch_rx_idle[1] <= 1'h0;
    cyc(1);
    ch_rx_idle <= 2'h3;
    cyc(225);
    rchk(A_GSTAT, 32'h0040_0000, 32'h0000_0000, "f0 restart");
    cyc(40);
    rchk(A_GSTAT, 32'h0040_0000, 32'h0040_0000, "f0 pd status");
    i_host.wr(A_GSTAT, 32'h0F00_0000);
    ch_irq_pend <= 2'h1;
    cyc(1);
    ch_irq_pend <= 2'h0;
    cyc(260);
    ochk(32'h0000_0100, 32'h0000_0100, "f0 irq");
    i_host.wr(A_FILT, 32'h0000_0000);
    $display("test f0 filter finished");

    // Wake tests run with the filter disabled
    i_host.wr(A_PM0, pm_word(PS_D3, 1'h1, 1'h0));
    cyc(2);
    ochk(32'h0000_0056, 32'h0000_0000, "f0 low gates");
    i_host.wr(A_PM0, pm_word(PS_D1, 1'h1, 1'h0));
    rchk(A_PM0, 32'h0000_8103, pm_word(PS_D3, 1'h1, 1'h0), "f0 stays d3");
    repeat (16) begin
      lf = lfsr(lf);
      modem_in <= {lf, lf[1:0]} & 10'h2F7;
      cyc(1);
    end
    cyc(8);
    ochk(32'h0000_0200, 32'h0000_0200, "d3 no wake");
    modem_in <= modem_in | 10'h008;
    cyc(8);
    ochk(32'h0000_0200, 32'h0000_0200, "ring lead");
    modem_in <= modem_in & 10'h3F7;
    cyc(8);
    ochk(32'h0000_0600, 32'h0000_0000, "ring wake");
    cyc(20);
    rchk(A_PM0, 32'h0000_8000, 32'h0000_8000, "wake status");
    ochk(32'h0000_0200, 32'h0000_0000, "wake held");
    i_host.wake_ack(A_PM0);
    cyc(3);
    ochk(32'h0000_0256, 32'h0000_0256, "wake released");
    $display("test d3 wake finished");

    i_host.wr(A_WMASK, 32'h0000_0100);
    i_host.wr(A_PM0, pm_word(PS_D2, 1'h1, 1'h0));
    cyc(4);
    modem_in <= modem_in ^ 10'h020;
    cyc(8);
    ochk(32'h0000_0200, 32'h0000_0200, "masked no wake");
    modem_in <= modem_in ^ 10'h010;
    cyc(8);
    ochk(32'h0000_0206, 32'h0000_0002, "data wake");
    i_host.wake_ack(A_PM0);
    cyc(3);
    $display("test d2 wake finished");

    i_host.wr(A_PM1, pm_word(PS_D3, 1'h1, 1'h1));
    cyc(3);
    ochk(32'h0000_0229, 32'h0000_0201, "f1 low");
    multipurpose_pin <= 2'h3;
    cyc(8);
    ochk(32'h0000_0200, 32'h0000_0000, "pin wake f1");
    rchk(A_PM0, 32'h0000_8000, 32'h0000_0000, "f0 untouched");
    multipurpose_pin <= 2'h1;
    // Pin wake is a level: let the synchroniser see it drop before the clear
    cyc(8);
    i_host.wake_ack(A_PM1);
    cyc(3);
    ochk(32'h0000_0229, 32'h0000_0228, "f1 released");
    i_host.wr(A_GSTAT, 32'h0700_0000);
    i_host.wr(A_PM0, pm_word(PS_D3, 1'h1, 1'h1));
    multipurpose_pin <= 2'h3;
    cyc(8);
    ochk(32'h0000_0200, 32'h0000_0000, "pin wake f0");
    rchk(A_PM1, 32'h0000_8000, 32'h0000_0000, "f1 untouched");
    $display("test pin wake finished");
    close_out();
  end
endmodule
`default_nettype wire
